/* pkg/drive_prot_pkg.sv */
// Constants, register map and types of the drive protection supervisor.
package drive_prot_pkg;
  localparam int CLK_HZ       = 100_000_000;
  localparam int TICK_MS      = 100;
  localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam logic [9:0] TENTHS_PER_S = 10'h00a;

  typedef enum logic [1:0] {RAMP_STOP, RAMP_ACCEL, RAMP_CONST, RAMP_DECEL} ramp_t;
  typedef enum logic [2:0] {SRC_KEYPAD, SRC_VOLT, SRC_CURR, SRC_SUM, SRC_COMM} ref_src_t;

  localparam logic [7:0] OFS_RATED     = 8'h00;
  localparam logic [7:0] OFS_WARN_LVL  = 8'h04;
  localparam logic [7:0] OFS_WARN_TIME = 8'h08;
  localparam logic [7:0] OFS_TRIP_EN   = 8'h0c;
  localparam logic [7:0] OFS_TRIP_LVL  = 8'h10;
  localparam logic [7:0] OFS_TRIP_TIME = 8'h14;
  localparam logic [7:0] OFS_STALL_MSK = 8'h18;
  localparam logic [7:0] OFS_STALL_LVL = 8'h1c;
  localparam logic [7:0] OFS_PH_EN     = 8'h20;
  localparam logic [7:0] OFS_TERM_SEL  = 8'h24;
  localparam logic [7:0] OFS_RELAY_SEL = 8'h28;
  localparam logic [7:0] OFS_FR_CFG    = 8'h2c;
  localparam logic [7:0] OFS_CRIT      = 8'h30;
  localparam logic [7:0] OFS_LOSS_MODE = 8'h34;
  localparam logic [7:0] OFS_LOSS_WAIT = 8'h38;
  localparam logic [7:0] OFS_IN4_FUNC  = 8'h3c;
  localparam logic [7:0] OFS_IN5_FUNC  = 8'h40;
  localparam logic [7:0] OFS_INV_RATED = 8'h44;
  localparam logic [7:0] OFS_REF_MIN   = 8'h48;
  localparam logic [7:0] OFS_STATUS    = 8'h4c;
  localparam logic [7:0] OFS_FAULT_CLR = 8'h50;

  localparam logic [7:0] WARN_LVL_MIN  = 8'h1e;
  localparam logic [7:0] WARN_LVL_MAX  = 8'h96;
  localparam logic [7:0] WARN_LVL_DEF  = 8'h96;
  localparam logic [7:0] WARN_TIME_MAX = 8'h1e;
  localparam logic [7:0] WARN_TIME_DEF = 8'h0a;
  localparam logic [7:0] TRIP_LVL_MIN  = 8'h1e;
  localparam logic [7:0] TRIP_LVL_MAX  = 8'hc8;
  localparam logic [7:0] TRIP_LVL_DEF  = 8'hb4;
  localparam logic [7:0] TRIP_TIME_MAX = 8'h3c;
  localparam logic [7:0] TRIP_TIME_DEF = 8'h3c;
  localparam logic [2:0] STALL_MSK_DEF = 3'h3;
  localparam logic [7:0] STALL_LVL_MIN = 8'h1e;
  localparam logic [7:0] STALL_LVL_MAX = 8'h96;
  localparam logic [7:0] STALL_LVL_DEF = 8'h96;
  localparam logic [7:0] LOSS_WAIT_MIN = 8'h0a;
  localparam logic [7:0] LOSS_WAIT_MAX = 8'h78;
  localparam logic [7:0] LOSS_WAIT_DEF = 8'h0a;
  localparam logic [7:0] ZERO8         = 8'h00;
  localparam logic [15:0] RATED_DEF    = 16'h0064;
  localparam logic [3:0] FR_CFG_DEF    = 4'hf;

  localparam int STALL_ACC = 0;
  localparam int STALL_CON = 1;
  localparam int STALL_DEC = 2;

  localparam logic [4:0] OUT_OL    = 5'h05;
  localparam logic [4:0] OUT_IOL   = 5'h06;
  localparam logic [4:0] OUT_STALL = 5'h07;
  localparam logic [4:0] OUT_LOSS  = 5'h0b;
  localparam logic [4:0] OUT_FAULT = 5'h11;
  localparam logic [4:0] OUT_MAX   = 5'h11;
  localparam logic [4:0] TERM_DEF  = 5'h0c;
  localparam logic [4:0] RELAY_DEF = 5'h11;
  localparam logic [4:0] IN_EXT_A  = 5'h12;
  localparam logic [4:0] IN_EXT_B  = 5'h13;
  localparam logic [4:0] IN_MAX    = 5'h18;
  localparam logic [4:0] IN4_DEF   = 5'h03;
  localparam logic [4:0] IN5_DEF   = 5'h04;

  localparam logic [1:0] CRIT_OFF   = 2'h0;
  localparam logic [1:0] CRIT_HALF  = 2'h1;
  localparam logic [1:0] CRIT_BELOW = 2'h2;
  localparam logic [1:0] MODE_KEEP  = 2'h0;
  localparam logic [1:0] MODE_FREE  = 2'h1;
  localparam logic [1:0] MODE_DECEL = 2'h2;

  localparam int FR_OL  = 0;
  localparam int FR_PH  = 1;
  localparam int FR_EXA = 2;
  localparam int FR_EXB = 3;
  localparam logic [15:0] LINK_LIMIT_DEF = 16'h017c;
endpackage

/* tb/drive_plant_model.sv */
// Behavioural model of the motor, the external sequence and the reference source.
module drive_plant_model
(
  input  wire logic                  clk_i,
  input  wire logic [15:0]           load_i,
  input  wire logic [15:0]           volt_i,
  input  wire drive_prot_pkg::ramp_t ramp_req_i,
  input  wire logic [2:0]            lost_i,
  input  wire logic [1:0]            pin_i,
  input  wire logic [15:0]           ref_i,
  input  wire logic                  cutoff_i,
  output drive_prot_pkg::ramp_t      ramp_o,
  output logic      [15:0]           current_o,
  output logic      [15:0]           link_volt_o,
  output logic      [2:0]            phase_lost_o,
  output logic      [1:0]            pin_o,
  output logic      [15:0]           ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import drive_prot_pkg::*;
  initial
  begin
    {current_o, link_volt_o, phase_lost_o, pin_o, ref_o} = '0;
    ramp_o = RAMP_STOP;
  end
  // A cut-off drive carries no current, so a trip must hold on without its cause.
  always @(posedge clk_i)
  begin
    current_o    <= cutoff_i ? 16'h0000 : load_i;
    link_volt_o  <= volt_i;
    ramp_o       <= ramp_req_i;
    phase_lost_o <= lost_i;
    pin_o        <= pin_i;
    ref_o        <= ref_i;
  end
endmodule

/* tb/test_drive_protection_supervisor.sv */
// Self-checking bench of the drive protection supervisor.
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module test_drive_protection_supervisor;
  timeunit 1ns;
  timeprecision 1ps;
  import drive_prot_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [15:0] load  = 16'h0;
  logic [15:0] volt  = 16'h0;
  logic [15:0] refv  = 16'h0;
  logic [2:0]  lost  = 3'h0;
  logic [1:0]  pin   = 2'h0;
  logic        comm  = 1'b1;
  ramp_t       ramp  = RAMP_STOP;
  ref_src_t    src   = SRC_KEYPAD;
  ramp_t       rmp;
  logic [31:0] rdata;
  logic [15:0] cur, lv, refo;
  logic [2:0]  ph;
  logic [1:0]  pins;
  logic        cutoff, hold, reduce, dstop, keep, fault, term, relay;
  int          n_errors = 0;
  int          n_checks = 0;
  always #5 clk_i = ~clk_i;
  drive_plant_model i_plant (.clk_i(clk_i), .load_i(load), .volt_i(volt), .ramp_req_i(ramp), .lost_i(lost),
    .pin_i(pin), .ref_i(refv), .cutoff_i(cutoff), .ramp_o(rmp), .current_o(cur), .link_volt_o(lv),
    .phase_lost_o(ph), .pin_o(pins), .ref_o(refo));
  drive_protection_supervisor #(.TICK_CYCLES(4), .LINK_LIMIT(LINK_LIMIT_DEF)) i_dut (.clk_i(clk_i),
    .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .current_i(cur), .link_volt_i(lv), .ramp_i(rmp), .phase_lost_i(ph), .multi_input_4_i(pins[0]),
    .multi_input_5_i(pins[1]), .ref_src_i(src), .voltage_ref_input_i(refo), .comm_ok_i(comm),
    .cutoff_o(cutoff), .ramp_hold_o(hold), .freq_reduce_o(reduce), .decel_stop_o(dstop),
    .keep_freq_o(keep), .fault_o(fault), .multi_output_terminal_o(term), .multi_output_relay_o(relay));
  task automatic go(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Checks wait 1 ns past the edge so the registered outputs have settled.
  task automatic at(input int n);
    go(n);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    go(1);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    go(1);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    go(1);
    addr <= a;
    rd   <= 1'b1;
    go(1);
    rd   <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  task automatic t_regs;
    logic [7:0]  a [9] = '{8'h18, 8'h1c, 8'h04, 8'h08, 8'h10, 8'h14, 8'h24, 8'h28, 8'hfc};
    logic [31:0] e [9] = '{32'h3, 32'h96, 32'h96, 32'ha, 32'hb4, 32'h3c, 32'hc, 32'h11, 32'h0};
    for (int i = 0; i < 9; i++)
      rd_chk(a[i], e[i]);
    wr_reg(8'h04, 32'hc8);
    rd_chk(8'h04, 32'h96);
    wr_reg(8'h08, 32'h28);
    rd_chk(8'h08, 32'h1e);
    wr_reg(8'h10, 32'hff);
    rd_chk(8'h10, 32'hc8);
    $display("t_regs done");
  endtask
  task automatic t_warn;
    wr_reg(8'h04, 32'h32);
    wr_reg(8'h08, 32'h1);
    wr_reg(8'h24, 32'h5);
    load <= 16'h3c;
    at(30);
    `CHK("warn", 1'b0, term)
    at(25);
    `CHK("warn", 1'b1, term)
    go(1);
    load <= 16'h28;
    at(4);
    `CHK("warn", 1'b0, term)
    $display("t_warn done");
  endtask
  task automatic t_stall;
    wr_reg(8'h18, 32'h1);
    wr_reg(8'h1c, 32'h32);
    wr_reg(8'h28, 32'h7);
    ramp <= RAMP_ACCEL;
    load <= 16'h3c;
    at(4);
    `CHK("hold", 1'b1, hold)
    `CHK("relay", 1'b1, relay)
    go(1);
    ramp <= RAMP_CONST;
    at(4);
    `CHK("reduce", 1'b0, reduce)
    wr_reg(8'h18, 32'h2);
    at(3);
    `CHK("reduce", 1'b1, reduce)
    wr_reg(8'h18, 32'h4);
    ramp <= RAMP_DECEL;
    volt <= LINK_LIMIT_DEF;
    at(4);
    `CHK("hold", 1'b0, hold)
    go(1);
    volt <= LINK_LIMIT_DEF + 16'h1;
    at(4);
    `CHK("hold", 1'b1, hold)
    go(1);
    ramp <= RAMP_STOP;
    load <= 16'h0;
    $display("t_stall done");
  endtask
  task automatic t_trip;
    wr_reg(8'h28, 32'h11);
    wr_reg(8'h0c, 32'h1);
    wr_reg(8'h10, 32'h32);
    wr_reg(8'h14, 32'h1);
    load <= 16'h3c;
    at(30);
    `CHK("cutoff", 1'b0, cutoff)
    at(25);
    `CHK("cutoff", 1'b1, cutoff)
    `CHK("fault", 1'b1, fault)
    `CHK("relay", 1'b1, relay)
    wr_reg(8'h2c, 32'he);
    at(3);
    `CHK("relay", 1'b0, relay)
    go(1);
    load <= 16'h0;
    wr_reg(8'h2c, 32'hf);
    wr_reg(8'h50, 32'h1);
    at(3);
    `CHK("cutoff", 1'b0, cutoff)
    wr_reg(8'h0c, 32'h0);
    $display("t_trip done");
  endtask
  task automatic t_phase;
    wr_reg(8'h20, 32'h1);
    lost <= 3'h2;
    at(3);
    `CHK("cutoff", 1'b1, cutoff)
    wr_reg(8'h50, 32'h1);
    at(3);
    `CHK("cutoff", 1'b1, cutoff)
    go(1);
    lost <= 3'h0;
    wr_reg(8'h50, 32'h1);
    at(3);
    `CHK("cutoff", 1'b0, cutoff)
    $display("t_phase done");
  endtask
  task automatic t_ext;
    go(1);
    pin <= 2'h2;
    go(4);
    wr_reg(8'h3c, 32'h12);
    wr_reg(8'h40, 32'h13);
    at(8);
    `CHK("fault", 1'b0, fault)
    go(1);
    pin <= 2'h3;
    at(8);
    `CHK("fault", 1'b1, fault)
    `CHK("cutoff", 1'b1, cutoff)
    go(1);
    pin <= 2'h2;
    go(8);
    wr_reg(8'h50, 32'h1);
    pin <= 2'h0;
    at(8);
    `CHK("fault", 1'b1, fault)
    go(1);
    pin <= 2'h2;
    go(8);
    wr_reg(8'h50, 32'h1);
    at(3);
    `CHK("fault", 1'b0, fault)
    $display("t_ext done");
  endtask
  task automatic t_loss;
    wr_reg(8'h48, 32'h64);
    wr_reg(8'h30, 32'h1);
    wr_reg(8'h24, 32'hb);
    src  <= SRC_VOLT;
    refv <= 16'h3c;
    at(60);
    `CHK("lost", 1'b0, term)
    go(1);
    refv <= 16'h28;
    at(30);
    `CHK("lost", 1'b0, term)
    at(20);
    `CHK("lost", 1'b1, term)
    for (int m = 0; m < 3; m++)
    begin
      wr_reg(8'h34, m);
      at(3);
      `CHK("keep", m == 0, keep)
      `CHK("cutoff", m == 1, cutoff)
      `CHK("dstop", m == 2, dstop)
    end
    go(1);
    src <= SRC_KEYPAD;
    at(5);
    `CHK("lost", 1'b0, term)
    wr_reg(8'h30, 32'h2);
    src  <= SRC_CURR;
    refv <= 16'h50;
    at(50);
    `CHK("lost", 1'b1, term)
    go(1);
    src <= SRC_COMM;
    at(3);
    `CHK("lost", 1'b0, term)
    go(1);
    comm <= 1'b0;
    at(50);
    `CHK("lost", 1'b1, term)
    wr_reg(8'h30, 32'h0);
    at(5);
    `CHK("lost", 1'b0, term)
    $display("t_loss done");
  endtask
  task automatic t_iol;
    wr_reg(8'h44, 32'h32);
    wr_reg(8'h28, 32'h6);
    load <= 16'h3c;
    at(4);
    `CHK("iol", 1'b1, relay)
    go(1);
    load <= 16'h28;
    at(4);
    `CHK("iol", 1'b0, relay)
    $display("t_iol done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    go(16);
    rst_n <= 1'b1;
    t_regs();
    t_warn();
    t_stall();
    t_trip();
    t_phase();
    t_ext();
    t_loss();
    t_iol();
    print_verdict();
  end
  initial
  begin
    #50000;
    n_errors++;
    print_verdict();
  end
endmodule

/* verilog/drive_protection_supervisor.sv */
// Protection supervisor: overload, stall, phase loss, external trip and reference loss.
//
// Contract
// R1: Warning level 30..150 percent of rated current, warning time 0..30 s.
// R2: Warning asserts after current stays above level for the time, drops below it.
// R3: Output code 5 routes the overload warning to the terminal.
// R4: Enabled overload trip cuts output above trip level for trip time.
// R5: Accelerating with mask bit 0, over stall level halts the ramp.
// R6: Constant run with mask bit 1, over stall level reduces frequency.
// R7: Decelerating with mask bit 2, link voltage above threshold halts ramp.
// R8: Stall mask is three bits, default 3, bits for accel, constant, decel.
// R9: Stall level is a percentage of motor rated current, default 150.
// R10: Output code 7 shows stall prevention acting.
// R11: Stall holds may lengthen a ramp beyond its configured time.
// R12: Phase loss enabled cuts output when any output phase is lost.
// R13: Input code 18 trips while the input is on.
// R14: Input code 19 trips while the input is off.
// R15: Current above inverter rating raises an alarm on the selected output.
// R16: Loss criterion: 0 off, 1 below half minimum, 2 below minimum.
// R17: Criterion 1 declares loss below half the configured minimum.
// R18: Loss check only for voltage, current, sum or communication source.
// R19: After the wait, mode 0 keeps, 1 free-runs, 2 decelerates to stop.
// R20: Output code 11 shows loss of frequency command.
// R21: Output code 17 follows the trips chosen by the fault relay mask.
// R22: Trips latch cut-off until cleared and override stall and warning.
//
// Decided for this implementation: the register offsets and the strobed register port.
module drive_protection_supervisor
  import drive_prot_pkg::*;
#(
  parameter int unsigned  TICK_CYCLES = drive_prot_pkg::TICK_CYC_DEF,
  parameter logic [15:0]  LINK_LIMIT  = drive_prot_pkg::LINK_LIMIT_DEF
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_n_i,
  input  wire logic [7:0]                addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [31:0]               rdata_o,
  input  wire logic [15:0]               current_i,
  input  wire logic [15:0]               link_volt_i,
  input  wire drive_prot_pkg::ramp_t     ramp_i,
  input  wire logic [2:0]                phase_lost_i,
  input  wire logic                      multi_input_4_i,
  input  wire logic                      multi_input_5_i,
  input  wire drive_prot_pkg::ref_src_t  ref_src_i,
  input  wire logic [15:0]               voltage_ref_input_i,
  input  wire logic                      comm_ok_i,
  output logic                           cutoff_o,
  output logic                           ramp_hold_o,
  output logic                           freq_reduce_o,
  output logic                           decel_stop_o,
  output logic                           keep_freq_o,
  output logic                           fault_o,
  output logic                           multi_output_terminal_o,
  output logic                           multi_output_relay_o
);
  import drive_prot_pkg::*;

  typedef struct packed {
    logic [15:0] rated;
    logic [15:0] inv_rated;
    logic [15:0] ref_min;
    logic [7:0]  warn_lvl;
    logic [7:0]  warn_time;
    logic [7:0]  trip_lvl;
    logic [7:0]  trip_time;
    logic [7:0]  stall_lvl;
    logic [7:0]  loss_wait;
    logic        trip_en;
    logic        ph_en;
    logic [2:0]  stall_mask;
    logic [4:0]  term_sel;
    logic [4:0]  relay_sel;
    logic [4:0]  in4_func;
    logic [4:0]  in5_func;
    logic [3:0]  fr_cfg;
    logic [1:0]  crit;
    logic [1:0]  loss_mode;
    logic [2:0]  s4;
    logic [2:0]  s5;
    logic        f4;
    logic        f5;
    logic [23:0] tick_cnt;
    logic        tick;
    logic [9:0]  warn_cnt;
    logic [9:0]  trip_cnt;
    logic [7:0]  loss_cnt;
    logic        warn;
    logic        iol;
    logic        stall_act;
    logic        ref_lost;
    logic [3:0]  trips;
    logic        cutoff;
    logic        fault;
    logic        hold;
    logic        reduce;
    logic        dstop;
    logic        keep;
    logic        mo;
    logic        relay;
    logic [31:0] rdata;
  } state_t;

  function automatic state_t reset_state();
    state_t s;
    s            = '0;
    s.rated      = RATED_DEF;
    s.inv_rated  = RATED_DEF;
    s.warn_lvl   = WARN_LVL_DEF;
    s.warn_time  = WARN_TIME_DEF;
    s.trip_lvl   = TRIP_LVL_DEF;
    s.trip_time  = TRIP_TIME_DEF;
    s.stall_lvl  = STALL_LVL_DEF;
    s.stall_mask = STALL_MSK_DEF;
    s.loss_wait  = LOSS_WAIT_DEF;
    s.term_sel   = TERM_DEF;
    s.relay_sel  = RELAY_DEF;
    s.in4_func   = IN4_DEF;
    s.in5_func   = IN5_DEF;
    s.fr_cfg     = FR_CFG_DEF;
    return s;
  endfunction

  localparam state_t RST = reset_state();

  // Percent compare done by cross-multiplying, so no divider is needed.
  function automatic logic over_pct(input logic [15:0] cur, input logic [7:0] pct, input logic [15:0] rated);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = cur * 24'h000064;
    rhs = pct * rated;
    return lhs > rhs;
  endfunction

  function automatic logic [7:0] clamp8(input logic [31:0] v, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] r;
    r = (v > {24'h0, hi}) ? hi : v[7:0];
    return (r < lo) ? lo : r;
  endfunction

  function automatic logic [4:0] clamp5(input logic [31:0] v, input logic [4:0] hi);
    return (v > {27'h0, hi}) ? hi : v[4:0];
  endfunction

  function automatic logic sel_out(input logic [4:0] code, input logic [4:0] f);
    logic r;
    r = 1'b0;
    if (code == OUT_OL)    r = f[0];
    if (code == OUT_IOL)   r = f[1];
    if (code == OUT_STALL) r = f[2];
    if (code == OUT_LOSS)  r = f[3];
    if (code == OUT_FAULT) r = f[4];
    return r;
  endfunction

  state_t     q;
  state_t     n;
  logic       ov_warn;
  logic       ov_trip;
  logic       ov_stall;
  logic       fault_clr;
  logic       any_trip;
  logic       hold_s;
  logic       red_s;
  logic       chk;
  logic       raw_loss;
  logic [9:0] warn_lim;
  logic [9:0] trip_lim;
  logic [3:0] trip_set;

  always_comb
  begin
    n        = q;
    hold_s   = 1'b0;
    red_s    = 1'b0;
    warn_lim = q.warn_time * TENTHS_PER_S;
    trip_lim = q.trip_time * TENTHS_PER_S;
    n.tick   = (q.tick_cnt == 24'(TICK_CYCLES - 1));
    n.tick_cnt = n.tick ? '0 : q.tick_cnt + 24'h000001;
    // Pins pass three flops; a level counts once the last two agree.
    n.s4 = {q.s4[1:0], multi_input_4_i};
    n.s5 = {q.s5[1:0], multi_input_5_i};
    if (q.s4[1] == q.s4[2])
      n.f4 = q.s4[2];
    if (q.s5[1] == q.s5[2])
      n.f5 = q.s5[2];
    fault_clr = wr_i && (addr_i == OFS_FAULT_CLR) && wdata_i[0];
    if (wr_i)
    begin
      case (addr_i)
        OFS_RATED:     n.rated = wdata_i[15:0];
        OFS_INV_RATED: n.inv_rated = wdata_i[15:0];
        OFS_REF_MIN:   n.ref_min = wdata_i[15:0];
        OFS_WARN_LVL:  n.warn_lvl = clamp8(wdata_i, WARN_LVL_MIN, WARN_LVL_MAX); // R1
        OFS_WARN_TIME: n.warn_time = clamp8(wdata_i, ZERO8, WARN_TIME_MAX); // R1
        OFS_TRIP_EN:   n.trip_en = wdata_i[0];
        OFS_TRIP_LVL:  n.trip_lvl = clamp8(wdata_i, TRIP_LVL_MIN, TRIP_LVL_MAX); // R4
        OFS_TRIP_TIME: n.trip_time = clamp8(wdata_i, ZERO8, TRIP_TIME_MAX); // R4
        OFS_STALL_MSK: n.stall_mask = wdata_i[2:0]; // R8
        OFS_STALL_LVL: n.stall_lvl = clamp8(wdata_i, STALL_LVL_MIN, STALL_LVL_MAX); // R9
        OFS_PH_EN:     n.ph_en = wdata_i[0];
        OFS_TERM_SEL:  n.term_sel = clamp5(wdata_i, OUT_MAX);
        OFS_RELAY_SEL: n.relay_sel = clamp5(wdata_i, OUT_MAX);
        OFS_FR_CFG:    n.fr_cfg = wdata_i[3:0];
        OFS_CRIT:      n.crit = (wdata_i[1:0] > CRIT_BELOW) ? CRIT_BELOW : wdata_i[1:0]; // R16
        OFS_LOSS_MODE: n.loss_mode = (wdata_i[1:0] > MODE_DECEL) ? MODE_DECEL : wdata_i[1:0];
        OFS_LOSS_WAIT: n.loss_wait = clamp8(wdata_i, LOSS_WAIT_MIN, LOSS_WAIT_MAX);
        OFS_IN4_FUNC:  n.in4_func = clamp5(wdata_i, IN_MAX);
        OFS_IN5_FUNC:  n.in5_func = clamp5(wdata_i, IN_MAX);
        default:       n.rated = q.rated;
      endcase
    end
    ov_warn  = over_pct(current_i, q.warn_lvl, q.rated);
    ov_trip  = over_pct(current_i, q.trip_lvl, q.rated);
    ov_stall = over_pct(current_i, q.stall_lvl, q.rated); // R9
    // Timers count tenths of a second and restart when current drops.
    if (!ov_warn)
      n.warn_cnt = '0;
    else if (q.tick && (q.warn_cnt < warn_lim))
      n.warn_cnt = q.warn_cnt + 10'h001;
    if (!(ov_trip && q.trip_en))
      n.trip_cnt = '0;
    else if (q.tick && (q.trip_cnt < trip_lim))
      n.trip_cnt = q.trip_cnt + 10'h001;
    trip_set[FR_OL] = q.trip_en && ov_trip && (q.trip_cnt >= trip_lim); // R4
    trip_set[FR_PH] = q.ph_en && (|phase_lost_i); // R12
    trip_set[FR_EXA] = ((q.in4_func == IN_EXT_A) && q.f4) || ((q.in5_func == IN_EXT_A) && q.f5); // R13
    trip_set[FR_EXB] = ((q.in4_func == IN_EXT_B) && !q.f4) || ((q.in5_func == IN_EXT_B) && !q.f5); // R14
    // A new trip wins over a clear arriving in the same cycle.
    n.trips  = trip_set | (q.trips & {4{!fault_clr}}); // R22
    any_trip = |n.trips;
    unique case (ramp_i)
      RAMP_ACCEL: hold_s = q.stall_mask[STALL_ACC] && ov_stall; // R5
      RAMP_CONST: red_s = q.stall_mask[STALL_CON] && ov_stall; // R6
      RAMP_DECEL: hold_s = q.stall_mask[STALL_DEC] && (link_volt_i > LINK_LIMIT); // R7
      RAMP_STOP:  hold_s = 1'b0;
    endcase
    chk = (q.crit != CRIT_OFF) && (ref_src_i inside {SRC_VOLT, SRC_CURR, SRC_SUM, SRC_COMM}); // R18
    if (ref_src_i == SRC_COMM)
      raw_loss = !comm_ok_i;
    else if (q.crit == CRIT_HALF)
      raw_loss = {voltage_ref_input_i, 1'b0} < {1'b0, q.ref_min}; // R17
    else
      raw_loss = voltage_ref_input_i < q.ref_min; // R16
    if (!(chk && raw_loss))
      n.loss_cnt = '0;
    else if (q.tick && (q.loss_cnt < q.loss_wait))
      n.loss_cnt = q.loss_cnt + 8'h01;
    n.ref_lost = chk && raw_loss && (q.loss_cnt >= q.loss_wait); // R19
    n.warn   = !any_trip && ov_warn && (q.warn_cnt >= warn_lim); // R2
    n.iol    = current_i > q.inv_rated; // R15
    // Holding the ramp is what stretches the ramp time; no ramp clock is kept here.
    n.hold   = !any_trip && hold_s; // R11
    n.reduce = !any_trip && red_s; // R6
    n.stall_act = n.hold || n.reduce; // R10
    n.cutoff = any_trip || (n.ref_lost && (q.loss_mode == MODE_FREE)); // R19
    n.fault  = any_trip; // R22
    n.keep   = !any_trip && n.ref_lost && (q.loss_mode == MODE_KEEP); // R19
    n.dstop  = !any_trip && n.ref_lost && (q.loss_mode == MODE_DECEL); // R19
    n.mo     = sel_out(n.term_sel, {|(n.trips & n.fr_cfg), n.ref_lost, n.stall_act, n.iol, n.warn}); // R3 R20
    n.relay  = sel_out(n.relay_sel, {|(n.trips & n.fr_cfg), n.ref_lost, n.stall_act, n.iol, n.warn}); // R21
    n.rdata  = '0;
    if (rd_i)
    begin
      case (addr_i)
        OFS_RATED:     n.rdata = {16'h0, q.rated};
        OFS_INV_RATED: n.rdata = {16'h0, q.inv_rated};
        OFS_REF_MIN:   n.rdata = {16'h0, q.ref_min};
        OFS_WARN_LVL:  n.rdata = {24'h0, q.warn_lvl};
        OFS_WARN_TIME: n.rdata = {24'h0, q.warn_time};
        OFS_TRIP_EN:   n.rdata = {31'h0, q.trip_en};
        OFS_TRIP_LVL:  n.rdata = {24'h0, q.trip_lvl};
        OFS_TRIP_TIME: n.rdata = {24'h0, q.trip_time};
        OFS_STALL_MSK: n.rdata = {29'h0, q.stall_mask};
        OFS_STALL_LVL: n.rdata = {24'h0, q.stall_lvl};
        OFS_PH_EN:     n.rdata = {31'h0, q.ph_en};
        OFS_TERM_SEL:  n.rdata = {27'h0, q.term_sel};
        OFS_RELAY_SEL: n.rdata = {27'h0, q.relay_sel};
        OFS_FR_CFG:    n.rdata = {28'h0, q.fr_cfg};
        OFS_CRIT:      n.rdata = {30'h0, q.crit};
        OFS_LOSS_MODE: n.rdata = {30'h0, q.loss_mode};
        OFS_LOSS_WAIT: n.rdata = {24'h0, q.loss_wait};
        OFS_IN4_FUNC:  n.rdata = {27'h0, q.in4_func};
        OFS_IN5_FUNC:  n.rdata = {27'h0, q.in5_func};
        OFS_STATUS:    n.rdata = {20'h0, q.trips, q.cutoff, q.ref_lost, q.stall_act, q.iol, q.warn, q.f5, q.f4, 1'b0};
        default:       n.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= RST;
    else
      q <= n;
  end

  assign rdata_o                 = q.rdata;
  assign cutoff_o                = q.cutoff;
  assign ramp_hold_o             = q.hold;
  assign freq_reduce_o           = q.reduce;
  assign decel_stop_o            = q.dstop;
  assign keep_freq_o             = q.keep;
  assign fault_o                 = q.fault;
  assign multi_output_terminal_o = q.mo;
  assign multi_output_relay_o    = q.relay;

  logic lost_done;
  assign lost_done = q.loss_cnt >= q.loss_wait;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_in4_on;
    (multi_input_4_i && (q.in4_func == IN_EXT_A))[*3];
  endsequence

  a_warn_range: assert property (q.warn_lvl inside {[WARN_LVL_MIN:WARN_LVL_MAX]} && q.warn_time <= WARN_TIME_MAX) // R1
    else $error("warning level or time out of range");
  a_warn_drop: assert property (!over_pct(current_i, q.warn_lvl, q.rated) |=> !q.warn) // R2
    else $error("warning stayed with current below level");
  a_mo_warn: assert property ((q.term_sel == OUT_OL) |-> (multi_output_terminal_o == q.warn)) // R3
    else $error("terminal does not follow warning");
  a_trip_latch: assert property (q.trips[FR_OL] && !fault_clr |=> q.trips[FR_OL] && cutoff_o) // R22
    else $error("overload trip not held");
  a_accel_hold: assert property (ramp_i == RAMP_ACCEL && q.stall_mask[STALL_ACC] && ov_stall |=> ramp_hold_o || cutoff_o) // R5
    else $error("accel stall did not hold ramp");
  a_const_red: assert property (ramp_i == RAMP_CONST && q.stall_mask[STALL_CON] && ov_stall |=> freq_reduce_o || cutoff_o) // R6
    else $error("constant run stall did not reduce");
  a_decel_hold: assert property (ramp_i == RAMP_DECEL && q.stall_mask[STALL_DEC] && link_volt_i > LINK_LIMIT |=> ramp_hold_o || cutoff_o) // R7
    else $error("decel stall did not hold ramp");
  a_trip_prio: assert property ((ramp_hold_o || freq_reduce_o || q.warn) |-> !fault_o) // R22
    else $error("stall or warning active during trip");
  a_phase_cut: assert property (q.ph_en && (|phase_lost_i) |=> cutoff_o && q.trips[FR_PH]) // R12
    else $error("phase loss did not cut output");
  a_ext_a_cut: assert property (s_in4_on |-> ##[3:4] (cutoff_o && fault_o)) // R13
    else $error("external trip A did not cut output");
  a_stall_mo: assert property ((q.term_sel == OUT_STALL) |-> (multi_output_terminal_o == q.stall_act)) // R10
    else $error("terminal does not follow stall");
  a_loss_wait: assert property ($rose(q.ref_lost) |-> $past(lost_done)) // R19
    else $error("reference loss before wait time");

  logic warn_done;
  logic trip_done;
  assign warn_done = q.warn_cnt >= warn_lim;
  assign trip_done = q.trip_cnt >= trip_lim;

  sequence s_in5_off;
    (!multi_input_5_i && (q.in5_func == IN_EXT_B))[*3];
  endsequence

  a_ext_b_cut: assert property (s_in5_off |-> ##[3:4] (cutoff_o && fault_o)) // R14
    else $error("external trip B did not cut output");
  a_iol_flag: assert property (current_i > q.inv_rated |=> q.iol) // R15
    else $error("inverter overload missed");
  a_crit_off: assert property (q.crit == CRIT_OFF |=> !q.ref_lost) // R16
    else $error("reference loss with check off");
  a_loss_mo: assert property ((q.term_sel == OUT_LOSS) |-> (multi_output_terminal_o == q.ref_lost)) // R20
    else $error("terminal does not follow loss");
  a_warn_time: assert property ($rose(q.warn) |-> $past(warn_done)) // R2
    else $error("warning before its time");
  a_trip_time: assert property ($rose(q.trips[FR_OL]) |-> $past(trip_done)) // R4
    else $error("overload trip before its time");
  a_relay_fault: assert property ((q.relay_sel == OUT_FAULT) |-> (multi_output_relay_o == |(q.trips & q.fr_cfg))) // R21
    else $error("relay does not follow trips");
  a_keep_lost: assert property (keep_freq_o |-> (q.ref_lost && !fault_o)) // R19
    else $error("keep frequency without loss");
  a_fault_cut: assert property (fault_o |-> cutoff_o) // R22
    else $error("fault without cut-off");
  a_stall_relay: assert property ((q.relay_sel == OUT_STALL) |-> (multi_output_relay_o == q.stall_act)) // R10
    else $error("relay does not follow stall");
endmodule
